// ---- rtl/atfd_task_file.sv ----
// Task-file register bank with address decode and byte-lane steering.
// Assumes host strobes and address arrive asynchronously on pins and the
// media engine sits on the same clock, driving status and error events.
// Function
// [R01] Fixed I/O base 1F/17 maps offsets 0-7
// [R02] Base 3F/37: offset 6 altstat/ctl, 7 drive
// [R03] Both enables low: offset 0 word access
// [R04] Low-enable byte pair: even then odd byte
// [R05] High-lane offset 0 byte reaches error/feature
// [R06] Data register overlaps error/feature at offset 1
// [R07] Contiguous map adds 8,9,D,E,F duplicates
// [R08] Memory mode: A10 high makes A0 pick data
// [R09] Host sets register select per mode
// [R10] IDE command select maps A2-A0 registers
// [R11] IDE control select, address 6: altstat/ctl
// [R12] IDE DMA acknowledge moves 16-bit words
// [R13] IDE PIO data 16-bit, or byte mode
// [R14] Data register is 16 bits, buffer path
// [R15] Error register read-only, bits 5,3,1 zero
// [R16] Error bits 7 bad block/CRC, 6 uncorrectable
// [R17] Error bit 4 sector not found, 0 general
// [R18] Error bit 2 on aborted command
// [R19] Feature register written, also via high lane
// [R20] Sector count zero means 256 sectors
// [R21] Count reads zero at success, remainder else
// [R22] Primary status read clears interrupt, alternate not
// [R23] True IDE only when strap held at power-up
// [R24] Unlisted decodes select nothing, ignore writes
// [R25] Drive data bus only on valid read
`timescale 1ns/10ps
module atfd_task_file
  import atfd_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ideStrap_n,
  input wire logic [1:0] configIndex,
  input wire logic regSelect_n,
  input wire logic low_byte_enable_n,
  input wire logic high_byte_enable_n,
  input wire logic command_block_select_n,
  input wire logic control_block_select_n,
  input wire logic dma_acknowledge_n,
  input wire logic io_read_strobe_n,
  input wire logic io_write_strobe_n,
  input wire logic memReadStrobe_n,
  input wire logic memWriteStrobe_n,
  input wire logic [10:0] addr,
  input wire logic [15:0] dataIn,
  input wire logic [7:0] engineStatus,
  input wire logic [7:0] engineDriveAddr,
  input wire logic bad_block_or_crc_flag,
  input wire logic uncorrectable_flag,
  input wire logic sector_not_found_flag,
  input wire logic command_aborted_flag,
  input wire logic general_error_flag,
  input wire logic cmdDone,
  input wire logic cmdOk,
  input wire logic [7:0] sectorsLeft,
  input wire logic engineIrq,
  input wire logic byteModeSet,
  input wire logic byteModeClear,
  input wire logic [15:0] bufRdWord,
  output logic [15:0] dataOut,
  output logic [15:0] dataOe,
  output logic cmdStrobe,
  output logic [7:0] commandCode,
  output logic [7:0] featureSel,
  output logic [8:0] sectorTotal,
  output logic [7:0] sectorNum,
  output logic [7:0] cylLow,
  output logic [7:0] cylHigh,
  output logic [7:0] cardHead,
  output logic [7:0] devControl,
  output logic bufWrStrobe,
  output logic [15:0] bufWrWord,
  output logic bufRdStrobe,
  output logic irqPending,
  output logic trueIdeMode
);

  //////////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed {
    logic [13:0] s1;        // First synchroniser stage for strobes and selects
    logic [13:0] s2;        // Second stage: the only one logic reads
    logic [10:0] a1;
    logic [10:0] a2;
    logic [15:0] d1;
    logic [15:0] d2;
    logic rdPrev;
    logic wrPrev;
    logic strapDone;
    logic ide;
    logic byteMode;
    logic evenPending;      // Byte-pair sequencer: next byte is odd
    logic [7:0] evenWr;
    logic [7:0] oddRd;
    logic [7:0] err;
    logic [7:0] feat;
    logic [7:0] secCnt;
    logic [7:0] secNum;
    logic [7:0] cylLo;
    logic [7:0] cylHi;
    logic [7:0] head;
    logic [7:0] cmd;
    logic [7:0] ctl;
    logic irq;
    logic cmdStb;
    logic bufWr;
    logic [15:0] bufWrW;
    logic bufRd;
    logic [15:0] dOut;
    logic [15:0] dOe;
  } atfd_state_t;

  atfd_state_t st_q;
  atfd_state_t st_d;

  //////////////////////////////////////////////////////////////////////////
  // Decode helpers

  // Contiguous map over 16 offsets, 13 of them decoded, also used by memory mode with A10 low
  function automatic atfd_sel_t atfd_contig(input logic [3:0] ofs);
    atfd_sel_t s;
    s = SEL_NONE;
    if (ofs == `ATFD_OFS_DATA) begin
      s = SEL_EVEN;
    end else if (ofs == `ATFD_OFS_ERRFEAT) begin
      s = SEL_ERRFEAT;
    end else if (ofs == `ATFD_OFS_SECCNT) begin
      s = SEL_SECCNT;
    end else if (ofs == `ATFD_OFS_SECNUM) begin
      s = SEL_SECNUM;
    end else if (ofs == `ATFD_OFS_CYLLO) begin
      s = SEL_CYLLO;
    end else if (ofs == `ATFD_OFS_CYLHI) begin
      s = SEL_CYLHI;
    end else if (ofs == `ATFD_OFS_CARDHEAD) begin
      s = SEL_CARDHEAD;
    end else if (ofs == `ATFD_OFS_STATCMD) begin
      s = SEL_STATCMD;
    end else if (ofs == `ATFD_OFS_DUPEVEN) begin
      s = SEL_EVEN; // [R07]
    end else if (ofs == `ATFD_OFS_DUPODD) begin
      s = SEL_ODD; // [R07]
    end else if (ofs == `ATFD_OFS_DUPERR) begin
      s = SEL_ERRFEAT; // [R07]
    end else if (ofs == `ATFD_OFS_ALTCTL) begin
      s = SEL_ALTCTL; // [R07]
    end else if (ofs == `ATFD_OFS_DRVADDR) begin
      s = SEL_DRVADDR; // [R07]
    end
    return s; // [R24]
  endfunction : atfd_contig

  // Card-mode lane steering of a low-offset selection by the byte enables
  function automatic atfd_sel_t atfd_lanes(input atfd_sel_t s, input logic ce1n,
                                           input logic ce2n, input logic [3:0] ofs);
    atfd_sel_t r;
    r = s;
    if (!ce1n && !ce2n && (ofs == `ATFD_OFS_DATA || ofs == `ATFD_OFS_ERRFEAT
        || ofs == `ATFD_OFS_DUPEVEN || ofs == `ATFD_OFS_DUPODD)) begin
      r = SEL_WORD; // [R03] [R06]
    end else if (ce1n && !ce2n && ofs == `ATFD_OFS_DATA) begin
      r = SEL_ERRFEAT; // [R05]
    end else if (ce1n && !ce2n && (ofs == `ATFD_OFS_DUPEVEN || ofs == `ATFD_OFS_DUPODD)) begin
      r = SEL_ODD;
    end else if (ce1n && ce2n) begin
      r = SEL_NONE; // [R24]
    end
    return r;
  endfunction : atfd_lanes

  //////////////////////////////////////////////////////////////////////////
  // Synchronised pin view

  logic rdN, wrN, mrdN, mwrN, ce1N, ce2N, cs0N, cs1N, dackN, regN, strapN;
  logic [10:0] aS;
  logic [15:0] dS;
  atfd_mode_t mode;
  atfd_sel_t sel;
  atfd_lane_t lane;
  logic rdAct, wrAct, rdRise, wrRise;
  logic [7:0] wrByte;
  logic [7:0] errView;

  // Only second-stage flops feed decoding
  assign {rdN, wrN, mrdN, mwrN, ce1N, ce2N, cs0N, cs1N, dackN, regN, strapN} = st_q.s2[10:0];
  assign aS = st_q.a2;
  assign dS = st_q.d2;

  // Mode: IDE strap wins, otherwise the configuration index picks the map
  always_comb begin
    if (st_q.ide) begin
      mode = MODE_TRUE_IDE; // [R23]
    end else if (configIndex == 2'h0) begin
      mode = MODE_MEMORY;
    end else if (configIndex == 2'h1) begin
      mode = MODE_CONTIG;
    end else if (configIndex == 2'h2) begin
      mode = MODE_FIXED_PRI;
    end else begin
      mode = MODE_FIXED_SEC;
    end
  end

  // Address decode per mode
  always_comb begin
    sel = SEL_NONE;
    if (mode == MODE_TRUE_IDE) begin
      if (cs1N && cs0N && !dackN) begin
        sel = SEL_WORD; // [R12]
      end else if (cs1N && !cs0N && dackN) begin
        sel = atfd_contig({1'b0, aS[2:0]}); // [R10]
        if (aS[2:0] == 3'h0) begin
          sel = st_q.byteMode ? SEL_EVEN : SEL_WORD; // [R13]
        end
      end else if (!cs1N && cs0N && dackN) begin
        if (aS[2:0] == 3'h6) begin
          sel = SEL_ALTCTL; // [R11]
        end else if (aS[2:0] == 3'h7) begin
          sel = SEL_DRVADDR;
        end
      end
    end else if (mode == MODE_MEMORY) begin
      if (regN && aS[10]) begin
        sel = atfd_lanes(aS[0] ? SEL_ODD : SEL_EVEN, ce1N, ce2N,
                         aS[0] ? `ATFD_OFS_DUPODD : `ATFD_OFS_DUPEVEN); // [R08]
      end else if (regN) begin
        sel = atfd_lanes(atfd_contig(aS[3:0]), ce1N, ce2N, aS[3:0]); // [R08] [R09]
      end
    end else if (mode == MODE_CONTIG) begin
      if (!regN) begin
        sel = atfd_lanes(atfd_contig(aS[3:0]), ce1N, ce2N, aS[3:0]); // [R07] [R09]
      end
    end else if (!regN) begin
      if (aS[9:4] == ((mode == MODE_FIXED_PRI) ? `ATFD_BASE_PRI_TASK : `ATFD_BASE_SEC_TASK)
          && !aS[3]) begin
        sel = atfd_lanes(atfd_contig(aS[3:0]), ce1N, ce2N, aS[3:0]); // [R01]
      end else if (aS[9:4] == ((mode == MODE_FIXED_PRI) ? `ATFD_BASE_PRI_CTL
                               : `ATFD_BASE_SEC_CTL) && aS[3:1] == 3'h3) begin
        sel = aS[0] ? SEL_DRVADDR : SEL_ALTCTL; // [R02]
      end
    end
  end

  // Strobes: I/O strobes except in memory mode; the access acts on the strobe's leading edge
  assign rdAct = (mode == MODE_MEMORY) ? !mrdN : !rdN;
  assign wrAct = (mode == MODE_MEMORY) ? !mwrN : !wrN;
  assign rdRise = rdAct && !st_q.rdPrev;
  assign wrRise = wrAct && !st_q.wrPrev;
  // High-lane byte access in card modes carries data on D15-D8
  assign lane = (sel == SEL_WORD) ? LANE_BOTH
              : (mode != MODE_TRUE_IDE && ce1N && !ce2N) ? LANE_HIGH : LANE_LOW;
  assign wrByte = (lane == LANE_HIGH) ? dS[15:8] : dS[7:0];
  // Fixed zero bits forced on read
  assign errView = st_q.err & `ATFD_ERR_ZERO_MASK; // [R15]

  //////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    logic [7:0] rdByte;
    rdByte = `ATFD_RST_BYTE;
    st_d = st_q;
    st_d.s1 = {3'h0, io_read_strobe_n, io_write_strobe_n, memReadStrobe_n, memWriteStrobe_n,
               low_byte_enable_n, high_byte_enable_n, command_block_select_n,
               control_block_select_n, dma_acknowledge_n, regSelect_n, ideStrap_n};
    st_d.s2 = st_q.s1;
    st_d.a1 = addr;
    st_d.a2 = st_q.a1;
    st_d.d1 = dataIn;
    st_d.d2 = st_q.d1;
    st_d.rdPrev = rdAct;
    st_d.wrPrev = wrAct;
    st_d.cmdStb = 1'b0;
    st_d.bufWr = 1'b0;
    st_d.bufRd = 1'b0;
    // Strap caught once, after reset has left the synchroniser settled
    if (!st_q.strapDone) begin
      st_d.strapDone = 1'b1;
      st_d.ide = !strapN; // [R23]
    end
    if (byteModeSet) begin
      st_d.byteMode = 1'b1; // [R13]
    end else if (byteModeClear) begin
      st_d.byteMode = 1'b0;
    end
    // Error detail is latched at command end; every command end clears it and loads the event flags
    if (cmdDone) begin
      st_d.err = '0;
      st_d.err[`ATFD_ERR_BBK_BIT] = bad_block_or_crc_flag; // [R16]
      st_d.err[`ATFD_ERR_UNC_BIT] = uncorrectable_flag; // [R16]
      st_d.err[`ATFD_ERR_SECTOR_NOT_FOUND_FLAG_BIT] = sector_not_found_flag; // [R17]
      st_d.err[`ATFD_ERR_COMMAND_ABORTED_FLAG_BIT] = command_aborted_flag; // [R18]
      st_d.err[`ATFD_ERR_GENERAL_ERROR_FLAG_BIT] = general_error_flag; // [R17]
      st_d.secCnt = cmdOk ? 8'h00 : sectorsLeft; // [R21]
    end
    // Writes: one register per leading edge, none for unlisted decodes
    if (wrRise) begin
      case (sel)
        SEL_WORD: begin
          st_d.bufWr = 1'b1; // [R14]
          st_d.bufWrW = dS;
          st_d.evenPending = 1'b0;
        end
        SEL_EVEN: begin
          if (mode == MODE_TRUE_IDE || st_q.evenPending) begin
            st_d.bufWr = 1'b1; // [R04]
            st_d.bufWrW = (mode == MODE_TRUE_IDE) ? {8'h00, dS[7:0]} : {dS[7:0], st_q.evenWr};
            st_d.evenPending = 1'b0;
          end else begin
            st_d.evenWr = dS[7:0]; // [R04]
            st_d.evenPending = 1'b1;
          end
        end
        SEL_ODD: begin
          st_d.bufWr = 1'b1; // [R04]
          st_d.bufWrW = {wrByte, st_q.evenWr};
          st_d.evenPending = 1'b0;
        end
        SEL_ERRFEAT: st_d.feat = wrByte; // [R19]
        SEL_SECCNT: st_d.secCnt = wrByte;
        SEL_SECNUM: st_d.secNum = wrByte;
        SEL_CYLLO: st_d.cylLo = wrByte;
        SEL_CYLHI: st_d.cylHi = wrByte;
        SEL_CARDHEAD: st_d.head = wrByte;
        SEL_STATCMD: begin
          st_d.cmd = wrByte;
          st_d.cmdStb = 1'b1;
        end
        SEL_ALTCTL: st_d.ctl = wrByte;
        default: ; // [R24]
      endcase
    end
    // Reads: byte pair takes a buffer word on the even half
    case (sel)
      SEL_EVEN: rdByte = (mode != MODE_TRUE_IDE && st_q.evenPending) ? st_q.oddRd
                       : bufRdWord[7:0]; // [R04]
      SEL_ODD: rdByte = st_q.oddRd;
      SEL_ERRFEAT: rdByte = errView;
      SEL_SECCNT: rdByte = st_q.secCnt;
      SEL_SECNUM: rdByte = st_q.secNum;
      SEL_CYLLO: rdByte = st_q.cylLo;
      SEL_CYLHI: rdByte = st_q.cylHi;
      SEL_CARDHEAD: rdByte = st_q.head;
      SEL_STATCMD, SEL_ALTCTL: rdByte = engineStatus;
      SEL_DRVADDR: rdByte = engineDriveAddr;
      default: rdByte = `ATFD_RST_BYTE;
    endcase
    if (rdRise) begin
      if (sel == SEL_WORD || (sel == SEL_EVEN && mode == MODE_TRUE_IDE)) begin
        st_d.bufRd = 1'b1; // [R14]
      end else if (sel == SEL_EVEN && !st_q.evenPending) begin
        st_d.bufRd = 1'b1; // [R04]
        st_d.oddRd = bufRdWord[15:8];
        st_d.evenPending = 1'b1;
      end else if (sel == SEL_ODD || sel == SEL_EVEN) begin
        st_d.evenPending = 1'b0;
      end
    end
    // Interrupt: engine event sets and wins over a clearing status read
    if (engineIrq) begin
      st_d.irq = 1'b1;
    end else if (rdRise && sel == SEL_STATCMD) begin
      st_d.irq = 1'b0; // [R22]
    end
    // Bus drive only while a valid read strobe is active
    st_d.dOe = '0;
    st_d.dOut = '0;
    if (rdAct && sel != SEL_NONE) begin
      if (lane == LANE_BOTH) begin
        st_d.dOe = 16'hffff;
        st_d.dOut = (sel == SEL_ERRFEAT) ? {errView, bufRdWord[7:0]} : bufRdWord;
      end else if (lane == LANE_HIGH) begin
        st_d.dOe = 16'hff00;
        st_d.dOut = {rdByte, 8'h00};
      end else begin
        st_d.dOe = 16'h00ff;
        st_d.dOut = {8'h00, rdByte};
      end
    end // [R25]
    // Read data frozen at the leading edge; pair state moves on under it
    if (rdAct && !rdRise) begin
      st_d.dOut = st_q.dOut;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Registers

  // Strobe and select synchronisers run through reset so the strap has settled at release
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      st_q <= '0;
      st_q.s1 <= st_d.s1;
      st_q.s2 <= st_d.s2;
      st_q.secCnt <= `ATFD_RST_SECCNT;
      st_q.head <= `ATFD_RST_CARDHEAD;
      st_q.bufWrW <= `ATFD_RST_WORD;
    end else begin
      st_q <= st_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Outputs from flops; sectorTotal and irqPending pass through gating logic

  assign dataOut = st_q.dOut;
  assign dataOe = st_q.dOe;
  assign cmdStrobe = st_q.cmdStb;
  assign commandCode = st_q.cmd;
  assign featureSel = st_q.feat;
  assign sectorTotal = {(st_q.secCnt == 8'h00), st_q.secCnt}; // [R20]
  assign sectorNum = st_q.secNum;
  assign cylLow = st_q.cylLo;
  assign cylHigh = st_q.cylHi;
  assign cardHead = st_q.head;
  assign devControl = st_q.ctl;
  assign bufWrStrobe = st_q.bufWr;
  assign bufWrWord = st_q.bufWrW;
  assign bufRdStrobe = st_q.bufRd;
  assign irqPending = st_q.irq && !st_q.ctl[`ATFD_CTL_IEN_N_BIT];
  assign trueIdeMode = st_q.ide;

endmodule : atfd_task_file

// ---- common/atfd_params.svh ----
// Address constants, field positions and reset values for the task-file decoder.
// Included by the package; definitions only.
`ifndef ATFD_PARAMS_SVH
`define ATFD_PARAMS_SVH
`define ATFD_OFS_DATA 4'h0
`define ATFD_OFS_ERRFEAT 4'h1
`define ATFD_OFS_SECCNT 4'h2
`define ATFD_OFS_SECNUM 4'h3
`define ATFD_OFS_CYLLO 4'h4
`define ATFD_OFS_CYLHI 4'h5
`define ATFD_OFS_CARDHEAD 4'h6
`define ATFD_OFS_STATCMD 4'h7
`define ATFD_OFS_DUPEVEN 4'h8
`define ATFD_OFS_DUPODD 4'h9
`define ATFD_OFS_DUPERR 4'hd
`define ATFD_OFS_ALTCTL 4'he
`define ATFD_OFS_DRVADDR 4'hf
`define ATFD_BASE_PRI_TASK 6'h1f
`define ATFD_BASE_SEC_TASK 6'h17
`define ATFD_BASE_PRI_CTL 6'h3f
`define ATFD_BASE_SEC_CTL 6'h37
`define ATFD_ERR_ZERO_MASK 8'hd5
`define ATFD_STAT_ERR_BIT 0
`define ATFD_ERR_BBK_BIT 7
`define ATFD_ERR_UNC_BIT 6
`define ATFD_ERR_SECTOR_NOT_FOUND_FLAG_BIT 4
`define ATFD_ERR_COMMAND_ABORTED_FLAG_BIT 2
`define ATFD_ERR_GENERAL_ERROR_FLAG_BIT 0
`define ATFD_CTL_IEN_N_BIT 1
`define ATFD_RST_BYTE 8'h00
`define ATFD_RST_WORD 16'h0000
`define ATFD_RST_SECCNT 8'h01
`define ATFD_RST_CARDHEAD 8'ha0
`endif

// ---- common/atfd_pkg.sv ----
// Types used by the task-file decoder; its bench does not import them.
// Assumes atfd_params.svh sits on the include path.
package atfd_pkg;
  `include "atfd_params.svh"

  // Register chosen by one decoded access
  typedef enum logic [3:0] {
    SEL_NONE, SEL_WORD, SEL_EVEN, SEL_ODD, SEL_ERRFEAT, SEL_SECCNT, SEL_SECNUM,
    SEL_CYLLO, SEL_CYLHI, SEL_CARDHEAD, SEL_STATCMD, SEL_ALTCTL, SEL_DRVADDR
  } atfd_sel_t;

  // Lane used by the selection; both lanes when it is a word
  typedef enum logic [1:0] {LANE_LOW, LANE_HIGH, LANE_BOTH} atfd_lane_t;

  // Card access path, picked from the config index and the IDE strap
  typedef enum logic [2:0] {
    MODE_FIXED_PRI, MODE_FIXED_SEC, MODE_CONTIG, MODE_MEMORY, MODE_TRUE_IDE
  } atfd_mode_t;
endpackage : atfd_pkg

// ---- verif/atfd_task_file_checker.sv ----
// Pin-level assertions for the task-file decoder.
// Assumes one clock, sync active-low reset, two-flop strobe sync.
`timescale 1ns/10ps
module atfd_task_file_checker (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic io_read_strobe_n,
  input wire logic io_write_strobe_n,
  input wire logic memReadStrobe_n,
  input wire logic memWriteStrobe_n,
  input wire logic cmdDone,
  input wire logic cmdOk,
  input wire logic [7:0] sectorsLeft,
  input wire logic engineIrq,
  input wire logic [15:0] dataOe,
  input wire logic cmdStrobe,
  input wire logic [8:0] sectorTotal,
  input wire logic [7:0] devControl,
  input wire logic bufWrStrobe,
  input wire logic bufRdStrobe,
  input wire logic irqPending,
  input wire logic trueIdeMode
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  ////////////////////////////////////////
  // Bus and strobe causes, three edges after the pin
  a_drive_needs_read: assert property (dataOe != 16'h0000 |->
    !$past(io_read_strobe_n, 3) || !$past(memReadStrobe_n, 3))
    else $error("data bus driven with no read strobe");
  a_lane_shape: assert property (dataOe inside {16'h0000, 16'h00ff, 16'hff00, 16'hffff})
    else $error("data bus driven on a partial lane");
  a_cmd_cause: assert property (cmdStrobe |->
    !$past(io_write_strobe_n, 3) || !$past(memWriteStrobe_n, 3))
    else $error("command pulse with no write strobe");
  a_cmd_single: assert property (cmdStrobe |=> !cmdStrobe)
    else $error("command pulse longer than one cycle");
  a_wr_from_write: assert property (bufWrStrobe |->
    ($past(io_write_strobe_n, 3) && $past(memWriteStrobe_n, 3)) == 1'b0 ##1 !bufWrStrobe)
    else $error("buffer write without host write");
  a_rd_from_read: assert property (bufRdStrobe |->
    !$past(io_read_strobe_n, 3) || !$past(memReadStrobe_n, 3))
    else $error("buffer read without host read");
  ////////////////////////////////////////
  // Sector count view, interrupt and mode strap
  a_count_range: assert property (sectorTotal inside {[9'h001:9'h100]})
    else $error("sector total outside 1 to 256");
  a_done_ok: assert property (cmdDone && cmdOk |=> sectorTotal == 9'h100)
    else $error("count not zero after success");
  a_done_left: assert property (cmdDone && !cmdOk && sectorsLeft != 8'h00 |=>
    sectorTotal == {1'b0, $past(sectorsLeft)})
    else $error("count not left after failure");
  a_irq_set: assert property (engineIrq && !devControl[1] |=> irqPending)
    else $error("interrupt not pending after event");
  a_irq_mask: assert property (devControl[1] |-> !irqPending)
    else $error("interrupt shown while disabled");
  a_mode_hold: assert property ($past(rst_b, 2) |-> $stable(trueIdeMode))
    else $error("mode changed outside reset");
endmodule : atfd_task_file_checker

bind atfd_task_file atfd_task_file_checker i_chk (.*);

// ---- verif/atfd_host_model.sv ----
// Host bus controller model driving card pins one cycle at a time.
// Assumes strobes pass two sync flops; spacing is generous.
`timescale 1ns/10ps
module atfd_host_model (
  input wire logic clk,
  input wire logic [15:0] dataOut,
  input wire logic [15:0] dataOe,
  output logic regSelect_n,
  output logic ce1n,
  output logic ce2n,
  output logic cs0n,
  output logic cs1n,
  output logic dmackn,
  output logic iorn,
  output logic iown,
  output logic mrn,
  output logic mwn,
  output logic [10:0] addr,
  output wire logic [15:0] dataIn
);
  logic hostOe;
  logic [15:0] hostD;
  logic [15:0] idle;
  initial begin
    {regSelect_n, ce1n, ce2n, cs0n, cs1n, dmackn, iorn, iown, mrn, mwn} = 10'h3ff;
    {hostOe, hostD, idle, addr} = '0;
  end
  // Undriven lanes toggle so a stale value never looks like data
  always @(posedge clk) idle <= ~idle;
  assign dataIn = hostOe ? hostD : ((dataOut & dataOe) | (idle & ~dataOe));
  ////////////////////////////////////////
  // One access: selects settle, strobe low, sample, release
  task automatic cyc(input logic [1:0] md, ce, input logic [2:0] cs,
      input logic [10:0] a, input logic wr, input logic [15:0] wd,
      output logic [15:0] rd, oe);
    @(posedge clk);
    regSelect_n <= md[1];
    {ce2n, ce1n} <= ce;
    {dmackn, cs1n, cs0n} <= cs;
    addr <= a;
    hostD <= wd;
    hostOe <= wr;
    repeat (3) @(posedge clk);
    if (md[0]) {mrn, mwn} <= wr ? 2'b10 : 2'b01;
    else {iorn, iown} <= wr ? 2'b10 : 2'b01;
    repeat (5) @(posedge clk);
    rd = dataIn;
    oe = dataOe;
    {iorn, iown, mrn, mwn} <= 4'hf;
    repeat (4) @(posedge clk);
    hostOe <= 1'b0;
    {ce2n, ce1n, dmackn, cs1n, cs0n} <= 5'h1f;
  endtask : cyc
endmodule : atfd_host_model

// ---- verif/ata_task_file_decoder_tb_top.sv ----
// Self-checking bench for the task-file decoder.
// Assumes 50 MHz clock; engine inputs driven here.
`timescale 1ns/10ps
`define CHK(n, e, g) begin nCompared++; if ((g) !== (e)) begin fails++; \
  $display("MISMATCH %s exp %h got %h", n, e, g); end end
module ata_task_file_decoder_tb_top;
  logic clk, rst_b, ideStrap_n, cmdDone, cmdOk, engineIrq, bmSet, bmClr;
  logic regSelect_n, ce1n, ce2n, cs0n, cs1n, dmackn, iorn, iown, mrn, mwn;
  logic cmdStrobe, bufWrStrobe, bufRdStrobe, irqPending, trueIdeMode;
  logic [1:0] configIndex, md;
  logic [2:0] cs;
  logic [4:0] errFlags;
  logic [8:0] sectorTotal;
  logic [10:0] addr;
  logic [7:0] engineStatus, engineDriveAddr, sectorsLeft, commandCode, featureSel;
  logic [7:0] sectorNum, cylLow, cylHigh, cardHead, devControl;
  logic [15:0] dataIn, dataOut, dataOe, bufWrWord, bufRdWord, rd, oe, lastWr;
  int fails, nCompared, nWr, nRd, nCmd;
  ////////////////////////////////////////
  atfd_task_file i_dut (.*, .low_byte_enable_n(ce1n), .high_byte_enable_n(ce2n),
    .command_block_select_n(cs0n), .control_block_select_n(cs1n), .dma_acknowledge_n(dmackn),
    .io_read_strobe_n(iorn), .io_write_strobe_n(iown), .memReadStrobe_n(mrn),
    .memWriteStrobe_n(mwn), .bad_block_or_crc_flag(errFlags[4]),
    .uncorrectable_flag(errFlags[3]), .sector_not_found_flag(errFlags[2]),
    .command_aborted_flag(errFlags[1]), .general_error_flag(errFlags[0]),
    .byteModeSet(bmSet), .byteModeClear(bmClr));
  atfd_host_model i_host (.*);
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // Count and keep what the decoder hands to the buffer and engine
  always @(posedge clk) begin
    if (bufWrStrobe) lastWr <= bufWrWord;
    nWr += bufWrStrobe;
    nRd += bufRdStrobe;
    nCmd += cmdStrobe;
  end
  ////////////////////////////////////////
  task automatic w(input logic [1:0] ce, input logic [10:0] a, input logic [15:0] d);
    i_host.cyc(md, ce, cs, a, 1'b1, d, rd, oe);
  endtask : w
  task automatic r(input logic [1:0] ce, input logic [10:0] a);
    i_host.cyc(md, ce, cs, a, 1'b0, 16'h0000, rd, oe);
  endtask : r
  task automatic rst(input logic strap);
    ideStrap_n <= strap;
    rst_b <= 1'b0;
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    repeat (2) @(posedge clk);
    `CHK("cardHead", 8'ha0, cardHead)
    `CHK("sectorTotal", 9'h001, sectorTotal)
    `CHK("ideMode", ~strap, trueIdeMode)
  endtask : rst
  task automatic done(input logic ok, input logic [7:0] left, input logic [4:0] f);
    {cmdDone, cmdOk, sectorsLeft, errFlags} <= {1'b1, ok, left, f};
    @(posedge clk);
    cmdDone <= 1'b0;
    @(posedge clk);
  endtask : done
  task automatic t_fixed;
    int k;
    configIndex <= 2'd2;
    for (int i = 2; i < 7; i++) begin
      w(2'b10, 11'h1f0 + i, 16'h0040 + i);
      r(2'b10, 11'h1f0 + i);
      `CHK("taskReg", 8'h40 + i, rd[7:0])
    end
    `CHK("cyl", 16'h4544, {cylHigh, cylLow})
    w(2'b10, 11'h174, 16'h0066);
    r(2'b10, 11'h1f4);
    `CHK("wrongBase", 8'h44, rd[7:0])
    k = nCmd;
    w(2'b10, 11'h1f7, 16'h00ec);
    `CHK("cmd", {k + 1, 8'hec}, {nCmd, commandCode})
    w(2'b10, 11'h3f6, 16'h0008);
    r(2'b10, 11'h3f7);
    `CHK("ctlDrv", 24'h0800ff, {devControl, oe})
    `CHK("drvAddr", 8'h3c, rd[7:0])
    configIndex <= 2'd3;
    r(2'b10, 11'h173);
    `CHK("secBase", 8'h43, rd[7:0])
  endtask : t_fixed
  task automatic t_data;
    int k;
    configIndex <= 2'd1;
    w(2'b00, 11'h2a0, 16'hbeef);
    `CHK("word", 16'hbeef, lastWr)
    k = nWr;
    w(2'b10, 11'h2a0, 16'h0012);
    w(2'b10, 11'h2a0, 16'h0034);
    `CHK("pair", {k + 1, 16'h3412}, {nWr, lastWr})
    k = nRd;
    r(2'b10, 11'h2a8);
    `CHK("evenRd", {k + 1, 8'ha5}, {nRd, rd[7:0]})
    r(2'b10, 11'h2a9);
    `CHK("oddRd", 8'hc3, rd[7:0])
    r(2'b10, 11'h2af);
    `CHK("drvF", 24'h3c00ff, {rd[7:0], oe})
  endtask : t_data
  task automatic t_err;
    logic [7:0] pos [5] = '{0, 2, 4, 6, 7};
    configIndex <= 2'd2;
    for (int i = 0; i < 5; i++) begin
      done(1'b0, 8'h00, 5'h01 << i);
      r(2'b01, 11'h1f0);
      `CHK("errHigh", {8'h01 << pos[i], 16'hff00}, {rd[15:8], oe})
    end
    done(1'b0, 8'h00, 5'h1f);
    w(2'b01, 11'h1f0, 16'h5a00);
    `CHK("featHigh", 8'h5a, featureSel)
    w(2'b10, 11'h1f1, 16'h00a7);
    r(2'b10, 11'h1f1);
    `CHK("errLow", 16'ha7d5, {featureSel, rd[7:0]})
  endtask : t_err
  task automatic t_count;
    configIndex <= 2'd1;
    w(2'b10, 11'h2a2, 16'h0000);
    `CHK("cnt256", 9'h100, sectorTotal)
    w(2'b10, 11'h2a2, 16'h0009);
    done(1'b1, 8'h07, 5'h00);
    r(2'b10, 11'h2a2);
    `CHK("cntOk", 8'h00, rd[7:0])
    done(1'b0, 8'h05, 5'h01);
    r(2'b10, 11'h2a2);
    `CHK("cntLeft", 8'h05, rd[7:0])
  endtask : t_count
  task automatic t_irq;
    engineIrq <= 1'b1;
    @(posedge clk);
    engineIrq <= 1'b0;
    r(2'b10, 11'h2ae);
    `CHK("altKeeps", 9'h151, {irqPending, rd[7:0]})
    r(2'b10, 11'h2a7);
    `CHK("statClr", 9'h051, {irqPending, rd[7:0]})
  endtask : t_irq
  task automatic t_mem;
    configIndex <= 2'd0;
    md = 2'b11;
    w(2'b10, 11'h003, 16'h0077);
    w(2'b10, 11'h5a0, 16'h0011);
    w(2'b10, 11'h7ff, 16'h0022);
    `CHK("memPair", 24'h772211, {sectorNum, lastWr})
    md = 2'b01;
    w(2'b10, 11'h003, 16'h0099);
    `CHK("regMismatch", 8'h77, sectorNum)
    md = 2'b00;
  endtask : t_mem
  task automatic t_ide;
    rst(1'b0);
    cs = 3'b110;
    w(2'b11, 11'h002, 16'h0020);
    r(2'b11, 11'h002);
    `CHK("ideTask", 24'h2000ff, {rd[7:0], oe})
    cs = 3'b101;
    w(2'b11, 11'h006, 16'h0004);
    `CHK("ideCtl", 8'h04, devControl)
    cs = 3'b011;
    w(2'b11, 11'h005, 16'h1234);
    r(2'b11, 11'h003);
    `CHK("dma", 48'h1234c3a5ffff, {lastWr, rd, oe})
    cs = 3'b110;
    r(2'b11, 11'h000);
    `CHK("pioWord", 16'hffff, oe)
    bmSet <= 1'b1;
    @(posedge clk);
    bmSet <= 1'b0;
    r(2'b11, 11'h000);
    `CHK("pioByte", 24'ha500ff, {rd[7:0], oe})
    cs = 3'b100;
    r(2'b11, 11'h007);
    `CHK("badSel", 16'h0000, oe)
  endtask : t_ide
  task automatic wrap_up;
    $display("Compared %0d, mismatches %0d", nCompared, fails);
    if (fails == 0 && nCompared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : wrap_up
  ////////////////////////////////////////
  initial begin
    {rst_b, cmdDone, cmdOk, engineIrq, bmSet, bmClr, errFlags, sectorsLeft} = '0;
    {ideStrap_n, configIndex, md, cs} = {1'b1, 2'd2, 2'd0, 3'b111};
    {engineStatus, engineDriveAddr, bufRdWord} = {8'h51, 8'h3c, 16'hc3a5};
    {fails, nCompared, nWr, nRd, nCmd, lastWr} = '0;
    rst(1'b1);
    t_fixed();
    t_data();
    t_err();
    t_count();
    t_irq();
    t_mem();
    t_ide();
    wrap_up();
  end
  // Run needs about 700 cycles
  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    wrap_up();
  end
endmodule : ata_task_file_decoder_tb_top
